// ==== hdl/cls2_pkg.sv ====
package cls2_pkg;

    // register map (offsets of our own)
    localparam logic [7:0] TXHOLD_OFS   = 8'h00;
    localparam logic [7:0] RXSTAT_OFS   = 8'h04;
    localparam logic [7:0] FLAGS_OFS    = 8'h08;
    localparam logic [7:0] CTRL_OFS     = 8'h0C;
    localparam logic [7:0] RXDATA_OFS   = 8'h10;

    // completion status bit positions
    localparam int OVR_BIT   = 7;
    localparam int BITT_BIT  = 6;
    localparam int INCB_BIT  = 5;
    localparam int CRCM_BIT  = 4;
    localparam int OWNOK_BIT = 3;
    localparam int BRK_BIT   = 2;
    localparam int IFR_BIT   = 1;
    localparam int IFRC_BIT  = 0;

    // flags register bit positions
    localparam int TBE_FBIT  = 0;
    localparam int TIDL_FBIT = 1;
    localparam int CCI_FBIT  = 2;
    localparam int BRKI_FBIT = 3;
    localparam int RBF_FBIT  = 4;

    // control register bit positions
    localparam int RXDMA_CBIT = 0;
    localparam int CDIS_CBIT  = 1;

    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // serialisation time of one byte
    localparam int SHIFT_CYCLES = 8;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       bit_err;
        logic       len_err;
        logic       crc_byte;
        logic       crc_bad;
        logic       first;
        logic       ifr;
    } rx_byte_t;

    typedef struct packed {
        logic       eof;
        logic       brk;
        logic       brk_rel;
    } rx_event_t;

endpackage : cls2_pkg

// ==== hdl/cls2_tx_status.sv ====
// Function
// - holding buffer empty after reset; any write marks it full
// - full buffer moves to shift register once shift register empties
// - buffer emptying sets empty flag and raises transmit dma request
// - buffer write clears empty flag and idle flag
// - completion status is read-only; reads leave it unchanged
// - status bits set on events, cleared after next good first byte
// - bit 7 set when two codes posted without a read between
// - status updates per byte; bit 6 on bit timing error
// - bit 5 set on byte not holding exactly eight bits
// - bit 4 set on check byte mismatch
// - bit 3 set on own good message; cleared by break
// - break sets bit 2, error bits may also be set
// - bit 1 on first good in-frame byte; bit 0 with check byte
// - codes 00h 02h 03h 08h 0Ah 0Bh 04h
// - own transmitted bytes loop back into receive buffer
// - completion interrupt flag set after end-of-frame interval
// - code held until next good first byte; faulty first byte suppresses flag
// - break during own transmission sets flag; release sets flags again
// - overrun holds pending transmission until status read
// - rx dma enable cleared when flag sets; full buffer overwritten
// - check byte test only while check disable bit clear
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module cls2_tx_status
(
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    // register port
    input  wire logic [7:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    // transmit dma
    input  wire logic              dma_wr_i,
    input  wire logic [7:0]        dma_wdata_i,
    output logic                   tx_dma_req_o,
    // receiver byte and frame events
    input  wire cls2_pkg::rx_byte_t  rx_i,
    input  wire cls2_pkg::rx_event_t ev_i,
    input  wire logic              tx_active_i,
    input  wire logic              tx_pending_i,
    // serialiser
    output logic      [7:0]        shift_o,
    output logic                   shift_busy_o,
    output logic                   tx_hold_off_o,
    output logic                   cc_irq_o,
    output logic                   rx_dma_en_o
);
    import cls2_pkg::*;

    logic [7:0] hold_r;
    logic       full_r;
    logic [3:0] shcnt_r;
    logic       tbe_r;
    logic       tidl_r;
    logic [7:0] stat_r;
    logic       posted_r;
    logic       first_bad_r;
    logic       cci_r;
    logic       brki_r;
    logic       rbf_r;
    logic [7:0] rxd_r;
    logic [7:0] ctrl_r;
    logic       hold_off_r;

    logic       bus_wr_tx;
    logic       any_wr_tx;
    logic [7:0] any_wdata;
    logic       load;
    logic       stat_rd;
    logic       good_byte;
    logic       post;
    logic       cci_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign bus_wr_tx = wr_i && hit(addr_i, TXHOLD_OFS);
    assign any_wr_tx = bus_wr_tx || dma_wr_i;
    assign any_wdata = bus_wr_tx ? wdata_i : dma_wdata_i;
    assign stat_rd   = rd_i && hit(addr_i, RXSTAT_OFS);
    // the check byte counts as data when the check is off
    // check gated
    assign good_byte = rx_i.valid && !rx_i.bit_err && !rx_i.len_err
                       && !(rx_i.crc_byte && rx_i.crc_bad && !ctrl_r[CDIS_CBIT]);
    assign post      = ev_i.eof || ev_i.brk || ev_i.brk_rel;
    assign cci_set   = ce_i && ((ev_i.eof && !first_bad_r)
                       || (ev_i.brk && tx_active_i) || ev_i.brk_rel);
    assign load      = full_r && (shcnt_r == 4'h0);

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            full_r <= 1'b0;
            hold_r <= 8'h00;
        end
        else if (ce_i)
        begin
            // a write beside a move refills at once
            if (any_wr_tx)
            begin
                full_r <= 1'b1;
                hold_r <= any_wdata;
            end
            else if (load)
                full_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            shcnt_r      <= 4'h0;
            shift_o      <= 8'h00;
            shift_busy_o <= 1'b0;
        end
        else if (ce_i)
        begin
            shift_busy_o <= load || (shcnt_r > 4'h1);
            if (load)
            begin
                shift_o <= hold_r;
                shcnt_r <= 4'(SHIFT_CYCLES);
            end
            else if (shcnt_r != 4'h0)
                shcnt_r <= shcnt_r - 4'h1;
        end
    end

    // empty flag and dma request; write clears; withdraw
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tbe_r        <= 1'b1;
            tidl_r       <= 1'b1;
            tx_dma_req_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (any_wr_tx)
            begin
                tbe_r        <= 1'b0;
                tidl_r       <= 1'b0;
                tx_dma_req_o <= 1'b0;
            end
            else if (load)
            begin
                tbe_r        <= 1'b1;
                tx_dma_req_o <= 1'b1;
            end
            else if (!full_r && shcnt_r == 4'h0 && !tx_active_i)
                tidl_r <= 1'b1;
        end
    end

    // status register, hardware only; reads do not alter it
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            stat_r <= STAT_RST;
        else if (ce_i)
        begin
            if (ev_i.brk)
            begin
                // break code; break clears own ok
                stat_r[BRK_BIT]   <= 1'b1;
                stat_r[OWNOK_BIT] <= 1'b0;
                stat_r[INCB_BIT]  <= stat_r[INCB_BIT] | (rx_i.valid && rx_i.len_err);
                stat_r[BITT_BIT]  <= stat_r[BITT_BIT] | (rx_i.valid && rx_i.bit_err);
            end
            else if (rx_i.valid)
            begin
                // reset only on good first byte of a new message
                if (rx_i.first && good_byte)
                begin
                    // codes 00h/02h, own transmit adds 08h; 03h needs a later check byte
                    stat_r <= {4'h0, tx_active_i, 1'b0, rx_i.ifr, 1'b0};
                    stat_r[OVR_BIT] <= posted_r && !stat_rd;
                end
                else
                begin
                    stat_r[BITT_BIT] <= stat_r[BITT_BIT] | rx_i.bit_err;
                    stat_r[INCB_BIT] <= stat_r[INCB_BIT] | rx_i.len_err;
                    stat_r[CRCM_BIT] <= stat_r[CRCM_BIT] |
                        (rx_i.crc_byte && rx_i.crc_bad && !ctrl_r[CDIS_CBIT]);
                    stat_r[IFR_BIT]  <= stat_r[IFR_BIT] | (rx_i.ifr && good_byte);
                    stat_r[IFRC_BIT] <= stat_r[IFRC_BIT] | (rx_i.ifr && rx_i.crc_byte
                        && !ctrl_r[CDIS_CBIT] && good_byte);
                end
            end
            else if (ev_i.eof)
            begin
                stat_r[OWNOK_BIT] <= stat_r[OWNOK_BIT]
                    && !(|stat_r[BITT_BIT:CRCM_BIT]);
                stat_r[OVR_BIT] <= stat_r[OVR_BIT] | (posted_r && !stat_rd);
            end
        end
    end

    // posted without a read; post wins over read
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            posted_r <= 1'b0;
        else if (ce_i)
        begin
            if (post)
                posted_r <= 1'b1;
            else if (stat_rd)
                posted_r <= 1'b0;
        end
    end

    // faulty first byte suppresses the frame-end flag
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            first_bad_r <= 1'b0;
        else if (ce_i && rx_i.valid && rx_i.first)
            first_bad_r <= !good_byte;
    end

    // completion flag; status read clears it; set wins
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cci_r <= 1'b0;
        else if (cci_set)
            cci_r <= 1'b1;
        else if (ce_i && stat_rd)
            cci_r <= 1'b0;
    end

    // break flag; set on break and release
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            brki_r <= 1'b0;
        else if (ce_i)
        begin
            if (ev_i.brk || ev_i.brk_rel)
                brki_r <= 1'b1;
            else if (rd_i && hit(addr_i, FLAGS_OFS))
                brki_r <= 1'b0;
        end
    end

    // looped-back bytes land here; overwrite when full
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rxd_r <= 8'h00;
            rbf_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rx_i.valid)
            begin
                rxd_r <= rx_i.data;
                rbf_r <= 1'b1;
            end
            else if (rd_i && hit(addr_i, RXDATA_OFS))
                rbf_r <= 1'b0;
        end
    end

    // overrun while waiting holds transmission off
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            hold_off_r <= 1'b0;
        else if (ce_i)
        begin
            if (rx_i.valid && rbf_r && tx_pending_i && !tx_active_i)
                hold_off_r <= 1'b1;
            else if (stat_rd)
                hold_off_r <= 1'b0;
        end
    end

    // rx dma enable dropped when flag sets
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ctrl_r <= CTRL_RST;
        else if (ce_i)
        begin
            if (wr_i && hit(addr_i, CTRL_OFS))
                ctrl_r <= {6'h00, wdata_i[CDIS_CBIT], wdata_i[RXDMA_CBIT]};
            if (cci_set)
                ctrl_r[RXDMA_CBIT] <= 1'b0;
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= 8'h00;
        else if (ce_i)
        begin
            if (!rd_i)
                rdata_o <= 8'h00;
            else if (hit(addr_i, TXHOLD_OFS))
                rdata_o <= hold_r;
            else if (hit(addr_i, RXSTAT_OFS))
                rdata_o <= stat_r;
            else if (hit(addr_i, FLAGS_OFS))
                rdata_o <= {3'h0, rbf_r, brki_r, cci_r, tidl_r, tbe_r};
            else if (hit(addr_i, CTRL_OFS))
                rdata_o <= ctrl_r;
            else if (hit(addr_i, RXDATA_OFS))
                rdata_o <= rxd_r;
            else
                rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_hold_off_o <= 1'b0;
            cc_irq_o      <= 1'b0;
            rx_dma_en_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_hold_off_o <= hold_off_r;
            cc_irq_o      <= cci_r;
            rx_dma_en_o   <= ctrl_r[RXDMA_CBIT];
        end
    end

    a_write_marks_full: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && any_wr_tx) |=> full_r && !tbe_r && !tidl_r)
        else $error("write did not fill buffer");
    a_empty_raises_req: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && load && !any_wr_tx) |=> tbe_r && tx_dma_req_o && !full_r)
        else $error("empty event without request");
    a_full_waits_shift: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (full_r && shcnt_r != 4'h0 && !any_wr_tx) |=> full_r)
        else $error("buffer left before shift empty");
    a_read_keeps_status: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (stat_rd && !rx_i.valid && !ev_i.brk && !ev_i.eof) |=> $stable(stat_r))
        else $error("read altered status");
    a_break_sets_code: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && ev_i.brk) |=> stat_r[BRK_BIT] && !stat_r[OWNOK_BIT])
        else $error("break code missing");
    a_bit_err_sticks: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && rx_i.valid && rx_i.bit_err) |=> stat_r[BITT_BIT])
        else $error("bit timing bit not set");
    a_len_err_sticks: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && rx_i.valid && rx_i.len_err) |=> stat_r[INCB_BIT])
        else $error("incomplete byte bit not set");
    a_flag_drops_dma: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cci_set |=> !ctrl_r[RXDMA_CBIT] ##1 !rx_dma_en_o)
        else $error("rx dma enable kept");
    a_eof_sets_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (ce_i && ev_i.eof && !first_bad_r) |=> cci_r ##1 cc_irq_o)
        else $error("frame end flag missing");
    a_overrun_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (hold_off_r && !stat_rd) |=> hold_off_r)
        else $error("hold-off released without read");

    c_tx_load: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        any_wr_tx ##[1:20] load);
    c_eof_irq: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        ev_i.eof ##2 cc_irq_o);
    c_break: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        ev_i.brk ##[1:50] ev_i.brk_rel);
    c_overrun: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        hold_off_r ##[1:20] stat_rd);

endmodule // cls2_tx_status
`default_nettype wire

// ==== sim/cls2_xcvr_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module cls2_xcvr_model
    import cls2_pkg::*;
(
    // clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rst_b_i,
    // serialiser side
    input  wire logic [7:0]    shift_i,
    input  wire logic          busy_i,
    // receive side
    output var  rx_byte_t      rx_o,
    output var  rx_event_t     ev_o
);
    logic busy_q = 1'b0;
    logic lb_q   = 1'b0;

    initial
    begin
        rx_o = '0;
        ev_o = '0;
    end

    // loop own bytes back
    // data flips once valid drops, so a stale byte never looks fresh
    always @(posedge mclk_i)
    begin
        busy_q <= rst_b_i & busy_i;
        lb_q   <= busy_q & ~busy_i;
        if (busy_q && !busy_i)
        begin
            rx_o       <= '0;
            rx_o.valid <= 1'b1;
            rx_o.data  <= shift_i;
        end
        else if (lb_q)
        begin
            rx_o.valid <= 1'b0;
            rx_o.data  <= ~rx_o.data;
        end
    end

    // f: first ifr check bad bit_err len_err
    task automatic send_byte(input logic [7:0] d, input logic [5:0] f);
        @(posedge mclk_i);
        rx_o <= '{valid: 1'b1, data: d, bit_err: f[1], len_err: f[0],
                  crc_byte: f[3], crc_bad: f[2], first: f[5], ifr: f[4]};
        @(posedge mclk_i);
        rx_o.valid <= 1'b0;
        rx_o.data  <= ~d;
    endtask

    // e: eof brk brk_rel
    task automatic pulse(input logic [2:0] e);
        @(posedge mclk_i);
        ev_o <= e;
        @(posedge mclk_i);
        ev_o <= '0;
    endtask
endmodule // cls2_xcvr_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cls2_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic       txa;
        logic [5:0] f1;
        logic [5:0] f2;
        logic       two;
        logic [7:0] exp;
    } row_t;

    logic       mclk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       dma_wr = 1'b0;
    logic [7:0] dma_wdata = 8'h00;
    logic       txa = 1'b0;
    logic       txp = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] rdata;
    logic [7:0] shift;
    logic       req, busy, hold, cc_irq, rxdma;
    rx_byte_t   rx;
    rx_event_t  ev;
    logic [7:0] v;
    int         n_mismatch = 0;
    int         tests_run = 0;

    row_t rows [11] = '{
        '{8'h00, 1'b0, 6'h20, 6'h00, 1'b0, 8'h00},
        '{8'h00, 1'b0, 6'h30, 6'h00, 1'b0, 8'h02},
        '{8'h00, 1'b0, 6'h30, 6'h18, 1'b1, 8'h03},
        '{8'h00, 1'b1, 6'h20, 6'h00, 1'b0, 8'h08},
        '{8'h00, 1'b1, 6'h30, 6'h00, 1'b0, 8'h0A},
        '{8'h00, 1'b1, 6'h30, 6'h18, 1'b1, 8'h0B},
        '{8'h00, 1'b0, 6'h20, 6'h02, 1'b1, 8'h40},
        '{8'h00, 1'b0, 6'h20, 6'h01, 1'b1, 8'h20},
        '{8'h00, 1'b0, 6'h20, 6'h0C, 1'b1, 8'h10},
        '{8'h02, 1'b0, 6'h20, 6'h0C, 1'b1, 8'h00},
        '{8'h02, 1'b0, 6'h30, 6'h18, 1'b1, 8'h02}};

    always #20 mclk_i = ~mclk_i;

    cls2_tx_status uut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .dma_wr_i(dma_wr), .dma_wdata_i(dma_wdata), .tx_dma_req_o(req),
        .rx_i(rx), .ev_i(ev), .tx_active_i(txa), .tx_pending_i(txp),
        .shift_o(shift), .shift_busy_o(busy), .tx_hold_off_o(hold),
        .cc_irq_o(cc_irq), .rx_dma_en_o(rxdma));

    cls2_xcvr_model xm (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .shift_i(shift), .busy_i(busy),
        .rx_o(rx), .ev_o(ev));

    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", s, e, g);
            n_mismatch++;
        end
    endtask

    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_i);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic br(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_i);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string s);
        logic [7:0] d;
        br(a, d);
        chk(s, e, d);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic wait_shift(input logic [7:0] e);
        for (int i = 0; i < 30; i++)
            if (shift !== e)
                wt(1);
        chk("shift byte", e, shift);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (4000) @(posedge mclk_i);
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end

    initial
    begin
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        wt(1);
        foreach (rows[i])
        begin
            bw(CTRL_OFS, rows[i].ctrl);
            txa <= rows[i].txa;
            br(RXSTAT_OFS, v);
            xm.send_byte(8'(i), rows[i].f1);
            if (rows[i].two)
                xm.send_byte(8'h55, rows[i].f2);
            rc(RXSTAT_OFS, rows[i].exp, "code row");
        end
        txa <= 1'b0;
        $display("code table test finished");

        // reset again in mid-run, so the table's leftovers must vanish
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        wt(1);
        chk("dma req reset", 8'h00, {7'h00, req});
        rc(FLAGS_OFS, 8'h03, "flags reset");
        rc(RXSTAT_OFS, 8'h00, "status reset");
        rc(CTRL_OFS, 8'h00, "control reset");
        $display("reset test finished");

        bw(TXHOLD_OFS, 8'hA5);
        bw(TXHOLD_OFS, 8'h3C);
        rc(FLAGS_OFS, 8'h00, "flags full");
        chk("shift first", 8'hA5, shift);
        chk("shift busy", 8'h01, {7'h00, busy});
        chk("dma req written", 8'h00, {7'h00, req});
        wait_shift(8'h3C);
        chk("dma req empty", 8'h01, {7'h00, req});
        @(posedge mclk_i);
        dma_wr    <= 1'b1;
        dma_wdata <= 8'h5A;
        @(posedge mclk_i);
        dma_wr    <= 1'b0;
        wt(1);
        chk("dma req dma", 8'h00, {7'h00, req});
        rc(FLAGS_OFS, 8'h10, "flags dma");
        wait_shift(8'h5A);
        wt(12);
        rc(RXDATA_OFS, 8'h5A, "looped byte");
        $display("transmit test finished");

        xm.send_byte(8'h66, 6'h22);
        rc(RXSTAT_OFS, 8'h40, "faulty first");
        xm.pulse(3'b100);
        wt(3);
        chk("no flag", 8'h00, {7'h00, cc_irq});
        bw(CTRL_OFS, 8'h01);
        wt(1);
        chk("rx dma on", 8'h01, {7'h00, rxdma});
        xm.send_byte(8'h77, 6'h20);
        xm.pulse(3'b100);
        wt(3);
        chk("flag on eof", 8'h01, {7'h00, cc_irq});
        chk("rx dma off", 8'h00, {7'h00, rxdma});
        xm.send_byte(8'h78, 6'h20);
        rc(RXSTAT_OFS, 8'h80, "lost code");
        wt(2);
        chk("flag read", 8'h00, {7'h00, cc_irq});
        bw(RXSTAT_OFS, 8'hFF);
        rc(RXSTAT_OFS, 8'h80, "status kept");
        $display("end of message test finished");

        txa <= 1'b1;
        xm.send_byte(8'h79, 6'h20);
        rc(RXSTAT_OFS, 8'h08, "own msg");
        xm.pulse(3'b010);
        wt(3);
        chk("flag on break", 8'h01, {7'h00, cc_irq});
        rc(RXSTAT_OFS, 8'h04, "break code");
        br(FLAGS_OFS, v);
        chk("break flags", 8'h08, v & 8'h0C);
        xm.pulse(3'b001);
        wt(3);
        chk("flag on release", 8'h01, {7'h00, cc_irq});
        br(FLAGS_OFS, v);
        chk("release flags", 8'h0C, v & 8'h0C);
        txa <= 1'b0;
        br(RXSTAT_OFS, v);
        $display("break test finished");

        br(RXDATA_OFS, v);
        xm.send_byte(8'h11, 6'h00);
        xm.send_byte(8'h22, 6'h00);
        rc(RXDATA_OFS, 8'h22, "overwrite");
        xm.send_byte(8'h33, 6'h00);
        txp <= 1'b1;
        xm.send_byte(8'h44, 6'h00);
        wt(3);
        chk("hold off", 8'h01, {7'h00, hold});
        br(RXSTAT_OFS, v);
        wt(3);
        chk("hold released", 8'h00, {7'h00, hold});
        txp <= 1'b0;
        rc(8'h20, 8'h00, "unmapped read");
        // a write while the clock enable is low must leave both flags set
        ce <= 1'b0;
        bw(TXHOLD_OFS, 8'h99);
        ce <= 1'b1;
        br(FLAGS_OFS, v);
        chk("frozen write", 8'h03, v & 8'h03);
        $display("overrun test finished");
        conclude();
    end
endmodule // testbench
`default_nettype wire
